// [rtl/ehbo_pkg.sv]
package ehbo_pkg;
  localparam logic [7:0] OP_XHD   = 8'h17;
  localparam logic [7:0] OP_DONLY = 8'h20;
  localparam logic [7:0] RSVD     = 8'h00;
  // word positions inside an order, most significant half first
  localparam logic [3:0] W_OP     = 4'h0;
  localparam logic [3:0] W_DA_HI  = 4'h1;
  localparam logic [3:0] W_DA_LO  = 4'h2;
  localparam logic [3:0] W_FW     = 4'h3;
  localparam logic [3:0] W_FH     = 4'h4;
  localparam logic [3:0] W_SA_HI  = 4'h5;
  localparam logic [3:0] W_SA_LO  = 4'h6;
  localparam logic [3:0] W_SW     = 4'h7;
  localparam logic [3:0] W_SCALE  = 4'h8;
  localparam logic [3:0] W_HXR    = 4'h9;
  localparam logic [3:0] W_HYR    = 4'ha;
  localparam logic [3:0] W_HA_HI  = 4'hb;
  localparam logic [3:0] W_HA_LO  = 4'hc;
  localparam logic [3:0] N_XHD    = 4'hd;
  localparam logic [3:0] N_DONLY  = 4'h5;
  localparam logic [3:0] N_OTHER  = 4'h1;
  // one bit per x scale field value; set bit means supported
  localparam logic [15:0] XSCALE_OK = 16'hffff;
  // axi4-lite register map, word indices
  localparam int         IDX_LSB  = 2;
  localparam int         BYTE_W   = 8;
  localparam logic [3:0] R_STAT   = 4'h0;
  localparam logic [3:0] R_CTRL   = 4'h1;
  localparam logic [3:0] R_DA     = 4'h2;
  localparam logic [3:0] R_SIZE   = 4'h3;
  localparam logic [3:0] R_SA     = 4'h4;
  localparam logic [3:0] R_SW     = 4'h5;
  localparam logic [3:0] R_SCALE  = 4'h6;
  localparam logic [3:0] R_HREM   = 4'h7;
  localparam logic [3:0] R_HA     = 4'h8;
  localparam logic [3:0] R_LOGIC  = 4'h9;
  localparam logic [3:0] R_HTDIM  = 4'ha;
  localparam logic [3:0] R_UBW    = 4'hb;
  localparam logic [3:0] R_LAST   = 4'hb;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef struct packed {
    logic [3:0] clip;
    logic [3:0] scale;
  } ehbo_scale_t;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } ehbo_w32_t;

  typedef struct packed {
    logic [15:0] unused;
    logic [7:0]  opcode;
    logic [6:0]  spare;
    logic        start;
  } ehbo_ctrl_t;

  typedef struct packed {
    logic [21:0] unused;
    logic [1:0]  dest;
    logic [7:0]  three;
  } ehbo_logic_t;

  typedef struct packed {
    logic [29:0] unused;
    logic        done;
    logic        busy;
  } ehbo_stat_t;

  typedef enum logic [2:0] {
    D_IDLE  = 3'b000,
    D_PARAM = 3'b001,
    D_START = 3'b010,
    D_RSRC  = 3'b011,
    D_RHT   = 3'b100,
    D_RDST  = 3'b101,
    D_WDST  = 3'b110,
    D_NEXT  = 3'b111
  } ehbo_dstate_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SEND = 2'b01,
    H_WAIT = 2'b10
  } ehbo_hstate_t;

  function automatic logic [3:0] ehbo_words(input logic [7:0] op);
    if (op == OP_XHD)
      return N_XHD;
    else if (op == OP_DONLY)
      return N_DONLY;
    else
      return N_OTHER;
  endfunction
endpackage

// [rtl/ehbo_if.sv]
`timescale 1ns/100ps
interface ehbo_if;
  logic        word_valid;
  logic        word_ready;
  logic [15:0] word_data;
  logic [7:0]  three_operand_logic_code;
  logic [1:0]  dest_logic_code;
  logic [15:0] ht_width;
  logic [15:0] ht_height;
  logic [31:0] ub_warp;
  logic        done;
  logic        busy;

  modport host (
    output word_valid,
    input  word_ready,
    output word_data,
    output three_operand_logic_code,
    output dest_logic_code,
    output ht_width,
    output ht_height,
    output ub_warp,
    input  done,
    input  busy
  );

  modport dev (
    input  word_valid,
    output word_ready,
    input  word_data,
    input  three_operand_logic_code,
    input  dest_logic_code,
    input  ht_width,
    input  ht_height,
    input  ub_warp,
    output done,
    output busy
  );
endinterface

// [rtl/ehbo_logic_unit.sv]
`timescale 1ns/100ps
module ehbo_logic_unit (
  input  wire logic       is_xhd,
  input  wire logic [7:0] three_code,
  input  wire logic [1:0] dest_code,
  input  wire logic       src,
  input  wire logic       ht,
  input  wire logic       dst,
  output wire logic       result
);
  // codes are truth tables indexed by the operand bits
  assign result = is_xhd ? three_code[{src, ht, dst}]
                         : dest_code[dst];
endmodule

// [rtl/ehbo_device.sv]
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
// What this block does
// - expanded halftone order: 0x17, zero, parameters
// - scale source up before combining
// - combine source, halftone, destination by three-operand code
// - halftone wraps at right and bottom edges
// - issuer defines halftone size beforehand
// - destination packed, warp equals frame width
// - only frame width by height processed
// - source lines step by order's source warp
// - earlier source warp setting ignored here
// - x scale low nibble, repeats 1 to 16
// - unsupported x scale means no x scaling
// - x clip high nibble skips left bits
// - y scale low nibble, lines repeat 1-16
// - y clip high nibble skips top lines
// - remainders count to halftone right, bottom
// - full size starts top left, one bottom right
// - halftone address matches frame corner, remainders
// - destination-only order: 0x20, zero, parameters
// - rewrite each destination pixel by dest code
// - destination lines step by unbanded warp
// - unbanded warp allows packed or unpacked
module ehbo_device (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  ehbo_if.dev              bus,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic             mem_wdata,
  input  wire logic        mem_rdata,
  input  wire logic        mem_ack
);
  ehbo_pkg::ehbo_dstate_t state;
  ehbo_pkg::ehbo_scale_t  xsc;
  ehbo_pkg::ehbo_scale_t  ysc;
  logic [7:0]  op;
  logic [3:0]  widx;
  logic [3:0]  nwords;
  logic [31:0] da;
  logic [31:0] sa;
  logic [31:0] ha;
  logic [15:0] fw;
  logic [15:0] fh;
  logic [15:0] sw;
  logic [15:0] ht_x_remain;
  logic [15:0] ht_y_remain;
  logic [31:0] d_line;
  logic [31:0] d_addr;
  logic [31:0] s_line;
  logic [31:0] s_addr;
  logic [31:0] h_line;
  logic [31:0] h_addr;
  logic [15:0] hx;
  logic [15:0] hy;
  logic [3:0]  xr;
  logic [3:0]  yr;
  logic [15:0] col;
  logic [15:0] row;
  logic        s_bit;
  logic        h_bit;
  logic        d_bit;
  logic        result;
  logic        take;
  logic        is_xhd;
  logic [3:0]  xs_eff;
  logic [3:0]  xc_eff;
  logic [31:0] dwarp;
  logic [31:0] ht_w32;
  logic [31:0] ht_span;

  assign take   = bus.word_valid && bus.word_ready;
  assign is_xhd = (op == ehbo_pkg::OP_XHD);
  assign nwords = (widx == ehbo_pkg::W_OP)
                  ? ehbo_pkg::ehbo_words(bus.word_data[15:8])
                  : ehbo_pkg::ehbo_words(op);
  // unsupported factor falls back to 1:1 and drops the clip with it
  assign xs_eff = ehbo_pkg::XSCALE_OK[xsc.scale] ? xsc.scale : 4'h0;
  assign xc_eff = ehbo_pkg::XSCALE_OK[xsc.scale] ? xsc.clip : 4'h0;
  assign dwarp  = is_xhd ? {16'h0, fw} : bus.ub_warp;
  assign ht_w32 = {16'h0, bus.ht_width};
  // offset from bottom halftone row back to top row, packed halftone
  assign ht_span = 32'(({16'h0, bus.ht_height} - 32'h1) * ht_w32);

  ehbo_logic_unit u_logic (
    .is_xhd     (is_xhd),
    .three_code (bus.three_operand_logic_code),
    .dest_code  (bus.dest_logic_code),
    .src        (s_bit),
    .ht         (h_bit),
    .dst        (d_bit),
    .result     (result)
  );

  // parameter capture, word by word, high half of long words first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      widx <= ehbo_pkg::W_OP;
      op   <= ehbo_pkg::RSVD;
      da   <= 32'h0;
      sa   <= 32'h0;
      ha   <= 32'h0;
      fw   <= 16'h0;
      fh   <= 16'h0;
      sw   <= 16'h0;
      ht_x_remain  <= 16'h0;
      ht_y_remain  <= 16'h0;
      xsc  <= '0;
      ysc  <= '0;
    end
    else if (take)
    begin
      widx <= (widx == 4'(nwords - 4'h1)) ? ehbo_pkg::W_OP : 4'(widx + 4'h1);
      case (widx)
        ehbo_pkg::W_OP:    op <= bus.word_data[15:8];
        ehbo_pkg::W_DA_HI: da[31:16] <= bus.word_data;
        ehbo_pkg::W_DA_LO: da[15:0] <= bus.word_data;
        ehbo_pkg::W_FW:    fw <= bus.word_data;
        ehbo_pkg::W_FH:    fh <= bus.word_data;
        ehbo_pkg::W_SA_HI: sa[31:16] <= bus.word_data;
        ehbo_pkg::W_SA_LO: sa[15:0] <= bus.word_data;
        ehbo_pkg::W_SW:    sw <= bus.word_data;
        ehbo_pkg::W_SCALE:
        begin
          xsc <= bus.word_data[15:8];
          ysc <= bus.word_data[7:0];
        end
        ehbo_pkg::W_HXR:   ht_x_remain <= bus.word_data;
        ehbo_pkg::W_HYR:   ht_y_remain <= bus.word_data;
        ehbo_pkg::W_HA_HI: ha[31:16] <= bus.word_data;
        ehbo_pkg::W_HA_LO: ha[15:0] <= bus.word_data;
        default:           op <= op;
      endcase
    end
  end

  // pixel walker: one read-modify-write per destination bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state          <= ehbo_pkg::D_IDLE;
      bus.word_ready <= 1'b0;
      bus.done       <= 1'b0;
      bus.busy       <= 1'b0;
      mem_req        <= 1'b0;
      mem_we         <= 1'b0;
      mem_addr       <= 32'h0;
      mem_wdata      <= 1'b0;
      {d_line, d_addr, s_line, s_addr, h_line, h_addr} <= '0;
      {hx, hy, col, row} <= '0;
      {xr, yr} <= '0;
      {s_bit, h_bit, d_bit} <= 3'h0;
    end
    else
    begin
      bus.done <= 1'b0;
      case (state)
        ehbo_pkg::D_IDLE:
        begin
          bus.word_ready <= 1'b1;
          if (take && nwords != ehbo_pkg::N_OTHER)
          begin
            state    <= ehbo_pkg::D_PARAM;
            bus.busy <= 1'b1;
          end
          else if (take)
            bus.done <= 1'b1;
        end
        ehbo_pkg::D_PARAM:
          if (take && widx == 4'(nwords - 4'h1))
          begin
            bus.word_ready <= 1'b0;
            state          <= ehbo_pkg::D_START;
          end
        ehbo_pkg::D_START:
        begin
          d_line <= da;
          d_addr <= da;
          s_line <= sa;
          s_addr <= sa;
          h_line <= ha;
          h_addr <= ha;
          hx     <= ht_x_remain;
          hy     <= ht_y_remain;
          xr     <= xc_eff;
          yr     <= ysc.clip;
          col    <= 16'h0;
          row    <= 16'h0;
          if (fw == 16'h0 || fh == 16'h0)
          begin
            state    <= ehbo_pkg::D_IDLE;
            bus.busy <= 1'b0;
            bus.done <= 1'b1;
          end
          else
            state <= is_xhd ? ehbo_pkg::D_RSRC : ehbo_pkg::D_RDST;
        end
        ehbo_pkg::D_RSRC, ehbo_pkg::D_RHT, ehbo_pkg::D_RDST:
          if (mem_req && mem_ack)
          begin
            mem_req <= 1'b0;
            if (state == ehbo_pkg::D_RSRC)
            begin
              s_bit <= mem_rdata;
              state <= ehbo_pkg::D_RHT;
            end
            else if (state == ehbo_pkg::D_RHT)
            begin
              h_bit <= mem_rdata;
              state <= ehbo_pkg::D_RDST;
            end
            else
            begin
              d_bit <= mem_rdata;
              state <= ehbo_pkg::D_WDST;
            end
          end
          else
          begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= (state == ehbo_pkg::D_RSRC) ? s_addr :
                        (state == ehbo_pkg::D_RHT) ? h_addr : d_addr;
          end
        ehbo_pkg::D_WDST:
          if (mem_req && mem_ack)
          begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            state   <= ehbo_pkg::D_NEXT;
          end
          else
          begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_addr  <= d_addr;
            mem_wdata <= result;
          end
        ehbo_pkg::D_NEXT:
          if (col == 16'(fw - 16'h1))
          begin
            col <= 16'h0;
            if (row == 16'(fh - 16'h1))
            begin
              // write already acked, so memory is current at done
              state    <= ehbo_pkg::D_IDLE;
              bus.busy <= 1'b0;
              bus.done <= 1'b1;
            end
            else
            begin
              row    <= 16'(row + 16'h1);
              state  <= is_xhd ? ehbo_pkg::D_RSRC : ehbo_pkg::D_RDST;
              d_line <= d_line + dwarp;
              d_addr <= d_line + dwarp;
              xr     <= xc_eff;
              hx     <= ht_x_remain;
              if (yr == ysc.scale)
              begin
                yr     <= 4'h0;
                s_line <= s_line + {16'h0, sw};
                s_addr <= s_line + {16'h0, sw};
              end
              else
              begin
                yr     <= 4'(yr + 4'h1);
                s_addr <= s_line;
              end
              if (hy == 16'h1)
              begin
                hy     <= bus.ht_height;
                h_line <= h_line - ht_span;
                h_addr <= h_line - ht_span;
              end
              else
              begin
                hy     <= 16'(hy - 16'h1);
                h_line <= h_line + ht_w32;
                h_addr <= h_line + ht_w32;
              end
            end
          end
          else
          begin
            col    <= 16'(col + 16'h1);
            state  <= is_xhd ? ehbo_pkg::D_RSRC : ehbo_pkg::D_RDST;
            d_addr <= d_addr + 32'h1;
            if (xr == xs_eff)
            begin
              xr     <= 4'h0;
              s_addr <= s_addr + 32'h1;
            end
            else
              xr <= 4'(xr + 4'h1);
            if (hx == 16'h1)
            begin
              hx     <= bus.ht_width;
              h_addr <= h_addr - (ht_w32 - 32'h1);
            end
            else
            begin
              hx     <= 16'(hx - 16'h1);
              h_addr <= h_addr + 32'h1;
            end
          end
        default:
          state <= ehbo_pkg::D_IDLE;
      endcase
    end
  end
endmodule

// [rtl/ehbo_host.sv]
`timescale 1ns/100ps
module ehbo_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  ehbo_if.host             bus
);
  ehbo_pkg::ehbo_hstate_t state;
  ehbo_pkg::ehbo_ctrl_t   ctrl;
  ehbo_pkg::ehbo_logic_t  lgc;
  ehbo_pkg::ehbo_w32_t    htdim;
  logic [31:0] cfg [ehbo_pkg::R_CTRL:ehbo_pkg::R_LAST];
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  wstrb_q;
  logic        aw_held;
  logic        w_held;
  logic        wr_fire;
  logic [5:0]  wr_idx;
  logic [5:0]  rd_idx;
  logic        done_flag;
  logic        start;
  logic [3:0]  widx;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx  = 6'(aw_q >> ehbo_pkg::IDX_LSB);
  assign rd_idx  = 6'(s_axi_araddr >> ehbo_pkg::IDX_LSB);
  assign ctrl    = cfg[ehbo_pkg::R_CTRL];
  assign lgc     = cfg[ehbo_pkg::R_LOGIC];
  assign bus.three_operand_logic_code = lgc.three;
  assign bus.dest_logic_code = lgc.dest;
  // halftone size must be set before the expanded order is started
  assign htdim         = cfg[ehbo_pkg::R_HTDIM];
  assign bus.ht_width  = htdim.hi;
  assign bus.ht_height = htdim.lo;
  assign bus.ub_warp   = cfg[ehbo_pkg::R_UBW];

  function automatic logic [15:0] word_at(input logic [3:0] i);
    ehbo_pkg::ehbo_w32_t da;
    ehbo_pkg::ehbo_w32_t sz;
    ehbo_pkg::ehbo_w32_t sa;
    ehbo_pkg::ehbo_w32_t hr;
    ehbo_pkg::ehbo_w32_t ha;
    ehbo_pkg::ehbo_w32_t sw;
    ehbo_pkg::ehbo_w32_t sc;
    da = cfg[ehbo_pkg::R_DA];
    sz = cfg[ehbo_pkg::R_SIZE];
    sa = cfg[ehbo_pkg::R_SA];
    hr = cfg[ehbo_pkg::R_HREM];
    ha = cfg[ehbo_pkg::R_HA];
    sw = cfg[ehbo_pkg::R_SW];
    sc = cfg[ehbo_pkg::R_SCALE];
    case (i)
      ehbo_pkg::W_OP:    return {ctrl.opcode, ehbo_pkg::RSVD};
      ehbo_pkg::W_DA_HI: return da.hi;
      ehbo_pkg::W_DA_LO: return da.lo;
      ehbo_pkg::W_FW:    return sz.hi;
      ehbo_pkg::W_FH:    return sz.lo;
      ehbo_pkg::W_SA_HI: return sa.hi;
      ehbo_pkg::W_SA_LO: return sa.lo;
      ehbo_pkg::W_SW:    return sw.lo;
      ehbo_pkg::W_SCALE: return sc.lo;
      ehbo_pkg::W_HXR:   return hr.hi;
      ehbo_pkg::W_HYR:   return hr.lo;
      ehbo_pkg::W_HA_HI: return ha.hi;
      ehbo_pkg::W_HA_LO: return ha.lo;
      default:           return 16'h0;
    endcase
  endfunction

  // write channel capture; address and data may come in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_q          <= 8'h0;
      w_q           <= 32'h0;
      wstrb_q       <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q          <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      else if (wr_fire)
      begin
        aw_held       <= 1'b0;
        s_axi_awready <= 1'b1;
      end
      else
        s_axi_awready <= !aw_held;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q          <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      else if (wr_fire)
      begin
        w_held       <= 1'b0;
        s_axi_wready <= 1'b1;
      end
      else
        s_axi_wready <= !w_held;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ehbo_pkg::RESP_OK;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_idx <= 6'(ehbo_pkg::R_LAST)) ? ehbo_pkg::RESP_OK
                                                      : ehbo_pkg::RESP_ERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  for (genvar i = ehbo_pkg::R_CTRL; i <= ehbo_pkg::R_LAST; i++)
  begin : g_reg
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        cfg[i] <= 32'h0;
      else if (wr_fire && wr_idx == 6'(i))
        for (int b = 0; b < 4; b++)
          if (wstrb_q[b])
            cfg[i][b*ehbo_pkg::BYTE_W +: ehbo_pkg::BYTE_W] <=
              w_q[b*ehbo_pkg::BYTE_W +: ehbo_pkg::BYTE_W];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= ehbo_pkg::RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= ehbo_pkg::RESP_OK;
      if (rd_idx == 6'(ehbo_pkg::R_STAT))
        s_axi_rdata <= {30'h0, done_flag,
                        state != ehbo_pkg::H_IDLE || bus.busy};
      else if (rd_idx <= 6'(ehbo_pkg::R_LAST))
        s_axi_rdata <= cfg[rd_idx[3:0]];
      else
      begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= ehbo_pkg::RESP_ERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else
      s_axi_arready <= !s_axi_rvalid;
  end

  // start is ignored while an order is still running
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      start <= 1'b0;
    else
      start <= wr_fire && wr_idx == 6'(ehbo_pkg::R_CTRL) && wstrb_q[0]
               && w_q[0] && state == ehbo_pkg::H_IDLE;
  end

  // done is sticky; a new completion beats a same-cycle clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      done_flag <= 1'b0;
    else if (state == ehbo_pkg::H_WAIT && bus.done)
      done_flag <= 1'b1;
    else if (wr_fire && wr_idx == 6'(ehbo_pkg::R_STAT) && wstrb_q[0]
             && w_q[1])
      done_flag <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state          <= ehbo_pkg::H_IDLE;
      bus.word_valid <= 1'b0;
      bus.word_data  <= 16'h0;
      widx           <= ehbo_pkg::W_OP;
    end
    else
      case (state)
        ehbo_pkg::H_IDLE:
          if (start)
          begin
            state          <= ehbo_pkg::H_SEND;
            bus.word_valid <= 1'b1;
            bus.word_data  <= word_at(ehbo_pkg::W_OP);
            widx           <= ehbo_pkg::W_OP;
          end
        ehbo_pkg::H_SEND:
          if (bus.word_ready)
          begin
            if (widx == 4'(ehbo_pkg::ehbo_words(ctrl.opcode) - 4'h1))
            begin
              bus.word_valid <= 1'b0;
              state          <= ehbo_pkg::H_WAIT;
            end
            else
            begin
              widx          <= 4'(widx + 4'h1);
              bus.word_data <= word_at(4'(widx + 4'h1));
            end
          end
        ehbo_pkg::H_WAIT:
          if (bus.done)
            state <= ehbo_pkg::H_IDLE;
        default:
          state <= ehbo_pkg::H_IDLE;
      endcase
  end
endmodule

// [test/ehbo_properties.sv]
`timescale 1ns/100ps
module ehbo_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        word_valid,
  input wire logic        word_ready,
  input wire logic [15:0] word_data,
  input wire logic        done
);
  logic [3:0] cnt;
  logic [7:0] op;
  logic       run;
  wire        tk = word_valid && word_ready;
  wire [7:0]  cur = cnt == 4'h0 ? word_data[15:8] : op;
  wire        last = tk && cnt + 4'h1 == ehbo_pkg::ehbo_words(cur);
  always_ff @(posedge aclk)
    cnt <= !aresetn || last ? 4'h0 : cnt + 4'(tk);
  always_ff @(posedge aclk)
    op <= tk && cnt == 4'h0 ? word_data[15:8] : op;
  // own flag, so a stuck device flag cannot hide a hang
  always_ff @(posedge aclk)
    run <= aresetn && !done && (run || last);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence last_s;
    last;
  endsequence
  hold_valid_a:
    assert property (word_valid && !word_ready |=> word_valid)
    else $error("word withdrawn");
  rsvd_byte_a:
    assert property (tk && cnt == 4'h0 |-> word_data[7:0] == 8'h00)
    else $error("reserved byte");
  xhd_len_a:
    assert property (tk && cnt == 4'hc && op == ehbo_pkg::OP_XHD
      |=> !word_ready) else $error("xhd length");
  donly_len_a:
    assert property (tk && cnt == 4'h4 && op == ehbo_pkg::OP_DONLY
      |=> !word_ready) else $error("donly length");
  run_gate_a:
    assert property (run && !done |-> !word_ready)
    else $error("ready in order");
  done_late_a:
    assert property (last_s |-> ##[1:1000] done)
    else $error("no done");
  done_pulse_a:
    assert property (done |=> !done)
    else $error("done too long");
  done_src_a:
    assert property (done |-> run)
    else $error("stray done");
endmodule

// [test/expanded_halftone_blit_orders_tb_top.sv]
`timescale 1ns/100ps
module expanded_halftone_blit_orders_tb_top;
  logic        aclk = 0, aresetn = 0, mem_ack = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, mem_req, mem_we;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, mem_wdata;
  logic        s_axi_arready, s_axi_rvalid, mem [512];
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, mem_addr, rd, e;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  wire         mem_rdata = mem[mem_addr[8:0]];
  int          error_cnt = 0, n_tests = 0;
  ehbo_if bus_i ();
  ehbo_host u_ehbo_host (.bus(bus_i), .*);
  ehbo_device u_ehbo_device (.bus(bus_i), .*);
  ehbo_properties u_ehbo_properties (.aclk, .aresetn, .done(bus_i.done),
    .word_valid(bus_i.word_valid), .word_ready(bus_i.word_ready),
    .word_data(bus_i.word_data));
  always #50 aclk = ~aclk;
  // ack never early, so every access waits on the handshake
  always @(posedge aclk)
  begin
    mem_ack <= mem_req && !mem_ack;
    if (mem_ack && mem_we) mem[mem_addr[8:0]] <= mem_wdata;
  end
  initial
  begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    finish_test();
  end
  function automatic logic pat(input int i);
    return i[0] ^ i[2];
  endfunction
  task automatic chk(input string n, input logic [31:0] x, g);
    n_tests++;
    if (g !== x)
    begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic go(input logic [7:0] op);
    wr(8'h04, {16'h0, op, 8'h01});
    chk("ctrl resp", ehbo_pkg::RESP_OK, rs);
    do rdr(8'h00); while (!rd[1]);
    chk("status", 32'h2, rd);
    wr(8'h00, 32'h2);
  endtask
  initial
  begin
    static logic [31:0] cfg [7] = '{32'hc8, 32'h30003, 32'h64, 32'h6,
                                    32'h1111, 32'h20002, 32'h32};
    for (int i = 0; i < 512; i++) mem[i] = pat(i);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdr(8'h30);
    chk("unmapped resp", ehbo_pkg::RESP_ERR, rs);
    wr(8'h30, 32'h1);
    chk("unmapped wr", ehbo_pkg::RESP_ERR, rs);
    // source warp 6, not frame width 3; scale 2 and clip 1 each way
    for (int k = 0; k < 7; k++) wr(8'h08 + 8'(4 * k), cfg[k]);
    rdr(8'h0c);
    chk("size readback", 32'h30003, rd);
    wr(8'h28, 32'h20002);
    for (int s = 0; s < 2; s++)
    begin
      wr(8'h24, s ? 32'hcc : 32'hf0);
      go(ehbo_pkg::OP_XHD);
      for (int i = 0; i < 10; i++)
      begin
        e = s ? pat(50 + i / 3 % 2 * 2 + i % 3 % 2)
              : pat(100 + (i / 3 + 1) / 2 * 6 + (i % 3 + 1) / 2);
        if (i == 9) e = pat(209);
        chk("xhd bit", e, mem[200 + i]);
      end
    end
    wr(8'h24, 32'h100);
    wr(8'h08, 32'h12c);
    wr(8'h0c, 32'h20002);
    wr(8'h2c, 32'h5);
    go(ehbo_pkg::OP_DONLY);
    for (int i = 0; i < 10; i++)
    begin
      e = pat(300 + i) ^ (i % 5 < 2);
      chk("donly bit", e, mem[300 + i]);
    end
    // unknown opcode: one word, then done with no memory traffic
    go(8'h55);
    finish_test();
  end
endmodule
